// ===== vecm_pkg.sv
// Package with register map, field positions and reset values for the vector-change detector.
package vecm_pkg;
    // Register byte addresses on the sensor's serial register interface.
    localparam logic [7:0] ADDR_EVENT_SRC = 8'h5e;
    localparam logic [7:0] ADDR_CONFIG = 8'h69;
    localparam logic [7:0] ADDR_THS_MSB = 8'h6a;
    localparam logic [7:0] ADDR_THS_LSB = 8'h6b;
    localparam logic [7:0] ADDR_DBNC_CNT = 8'h6c;
    localparam logic [7:0] ADDR_INITX_MSB = 8'h6d;
    localparam logic [7:0] ADDR_INITX_LSB = 8'h6e;
    localparam logic [7:0] ADDR_INITY_MSB = 8'h6f;
    localparam logic [7:0] ADDR_INITY_LSB = 8'h70;
    localparam logic [7:0] ADDR_INITZ_MSB = 8'h71;
    localparam logic [7:0] ADDR_INITZ_LSB = 8'h72;
    // Field positions inside the configuration register.
    localparam int CFG_LATCH = 6;
    localparam int CFG_INIT_SEL = 5;
    localparam int CFG_REF_HOLD = 4;
    localparam int CFG_ENABLE = 3;
    localparam int CFG_WAKE = 2;
    localparam int CFG_IRQ_EN = 1;
    localparam int CFG_ROUTE = 0;
    // Debounce mode bit inside the threshold high byte.
    localparam int THS_DBNC_MODE = 7;
    // Flag position inside the event source register.
    localparam int SRC_FLAG = 1;
    // Reset value shared by every register of this block.
    localparam logic [7:0] REG_RESET = 8'h00;
    // Widths of the magnetic samples and the threshold.
    localparam int MAG_W = 16;
    localparam int THS_W = 15;
endpackage

// ===== vecm_distance.sv
// Squared-distance comparator between the current magnetic sample and the references.
`timescale 1ns/1ps
`default_nettype none
module vecm_distance
    import vecm_pkg::*;
#(
    parameter int W = MAG_W,
    parameter int TW = THS_W
) (
    // Current sample and references.
    input wire logic signed [W-1:0] cur_x_i,
    input wire logic signed [W-1:0] cur_y_i,
    input wire logic signed [W-1:0] cur_z_i,
    input wire logic signed [W-1:0] ref_x_i,
    input wire logic signed [W-1:0] ref_y_i,
    input wire logic signed [W-1:0] ref_z_i,
    // Threshold and result.
    input wire logic [TW-1:0] ths_i,
    output logic above_o
);
    // The comparison is done on squares so that no root is needed.
    // Elaboration refuses widths that the squaring below cannot serve.
    if (W < 2 || TW < 1 || TW > W) begin : g_width_check
        $error("vecm_distance: unsupported widths");
    end

    // Squares one signed axis difference, widened so nothing overflows.
    function automatic logic [2*W+1:0] sq_diff(input logic signed [W-1:0] a, input logic signed [W-1:0] b);
        logic signed [W:0] d;
        logic [W:0] m;
        // Both operands are sign-extended by one bit, so the difference cannot wrap.
        d = {a[W-1], a} - {b[W-1], b};
        m = d[W] ? (W+1)'(-d) : (W+1)'(d);
        sq_diff = (2*W+2)'(m) * (2*W+2)'(m);
    endfunction

    logic [2*W+3:0] dist_sq; // Sum of the three squared differences.
    logic [2*W+3:0] ths_sq; // Squared threshold.

    // Combine the three axes and compare strictly against the threshold.
    always_comb begin
        dist_sq = (2*W+4)'(sq_diff(cur_x_i, ref_x_i)) + (2*W+4)'(sq_diff(cur_y_i, ref_y_i))
                + (2*W+4)'(sq_diff(cur_z_i, ref_z_i));
        ths_sq = (2*W+4)'(ths_i) * (2*W+4)'(ths_i);
        above_o = dist_sq > ths_sq;
    end
endmodule
`default_nettype wire

// ===== vecm_detect.sv
// Magnetic vector-magnitude change detector with configuration, debounce, references and routing.
//
// Notes on behaviour
// - Latched flag holds until source register read.
// - Unlatched flag follows every evaluation.
// - Init select zero loads current sample.
// - Init select one loads preset registers.
// - Hold zero: event overwrites all references.
// - Hold one: event leaves references unchanged.
// - Both set and enabled: preset writes apply immediately.
// - Enable starts and refreshes; clear stops detection.
// - Wake enable adds flag to auto-sleep activity.
// - Interrupt enable gates the interrupt output.
// - Route zero selects line b, one line a.
// - Event when distance exceeds threshold past debounce.
// - Below threshold: decrement or clear by mode.
// - Debounce counts rate ticks, halved in hybrid.
// - Flag reads as bit one of source.
`timescale 1ns/1ps
`default_nettype none
module vecm_detect
    import vecm_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic srst_i,
    // Register access from the serial interface logic.
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Magnetic samples at the output data rate.
    input wire logic sample_valid_i,
    input wire logic hybrid_i,
    input wire logic signed [MAG_W-1:0] mag_x_i,
    input wire logic signed [MAG_W-1:0] mag_y_i,
    input wire logic signed [MAG_W-1:0] mag_z_i,
    // Event outputs.
    output logic vecm_flag_o,
    output logic wake_activity_o,
    output logic irq_line_a_o,
    output logic irq_line_b_o
);
    // Whole block state in one record.
    typedef struct packed {
        logic [7:0] cfg; // Configuration register.
        logic dbnc_mode; // Debounce mode, clear when set.
        logic [THS_W-1:0] ths; // Magnitude threshold.
        logic [7:0] dbnc_cnt; // Programmed debounce count.
        logic [MAG_W-1:0] init_x; // Preset X reference.
        logic [MAG_W-1:0] init_y; // Preset Y reference.
        logic [MAG_W-1:0] init_z; // Preset Z reference.
        logic [MAG_W-1:0] ref_x; // Active X reference.
        logic [MAG_W-1:0] ref_y; // Active Y reference.
        logic [MAG_W-1:0] ref_z; // Active Z reference.
        logic [7:0] dcnt; // Running debounce counter.
        logic flag; // Vector-change flag.
        logic half; // Hybrid-mode tick divider.
        logic [7:0] rdata; // Read data holding register.
    } state_t;

    state_t st_reg; // Registered state.
    state_t st_next; // Next state.
    logic above; // Distance is over the threshold.
    logic tick; // One evaluation of the detector.
    logic evt; // Event fires this cycle.
    logic en_rise; // Configuration write that turns the function on.
    logic src_rd; // Host reads the source register.
    logic manual; // Preset writes go straight to the references.

    // Distance comparator against the active references.
    vecm_distance #(.W(MAG_W), .TW(THS_W)) u_dist (
        .cur_x_i(mag_x_i),
        .cur_y_i(mag_y_i),
        .cur_z_i(mag_z_i),
        .ref_x_i(st_reg.ref_x),
        .ref_y_i(st_reg.ref_y),
        .ref_z_i(st_reg.ref_z),
        .ths_i(st_reg.ths),
        .above_o(above)
    );

    // Read decode for the visible registers; unmapped addresses read zero.
    function automatic logic [7:0] read_mux(input state_t s, input logic [7:0] a);
        unique case (a)
            ADDR_EVENT_SRC: read_mux = 8'(s.flag) << SRC_FLAG;
            ADDR_CONFIG: read_mux = s.cfg;
            ADDR_THS_MSB: read_mux = {s.dbnc_mode, s.ths[14:8]};
            ADDR_THS_LSB: read_mux = s.ths[7:0];
            ADDR_DBNC_CNT: read_mux = s.dbnc_cnt;
            ADDR_INITX_MSB: read_mux = s.init_x[15:8];
            ADDR_INITX_LSB: read_mux = s.init_x[7:0];
            ADDR_INITY_MSB: read_mux = s.init_y[15:8];
            ADDR_INITY_LSB: read_mux = s.init_y[7:0];
            ADDR_INITZ_MSB: read_mux = s.init_z[15:8];
            ADDR_INITZ_LSB: read_mux = s.init_z[7:0];
            default: read_mux = 8'h00;
        endcase
    endfunction

    // Event qualifiers shared by the state update and the checks.
    always_comb begin
        // In hybrid mode only every second sample is evaluated.
        tick = sample_valid_i && (!hybrid_i || st_reg.half);
        evt = st_reg.cfg[CFG_ENABLE] && tick && above && (st_reg.dcnt >= st_reg.dbnc_cnt);
        en_rise = reg_wr_i && reg_addr_i == ADDR_CONFIG && reg_wdata_i[CFG_ENABLE] && !st_reg.cfg[CFG_ENABLE];
        src_rd = reg_rd_i && reg_addr_i == ADDR_EVENT_SRC;
        manual = st_reg.cfg[CFG_INIT_SEL] && st_reg.cfg[CFG_REF_HOLD] && st_reg.cfg[CFG_ENABLE];
    end

    // Next-state logic: registers, debounce, references and flag.
    always_comb begin
        st_next = st_reg;
        if (sample_valid_i) begin
            st_next.half = !st_reg.half;
        end
        // Register writes.
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_CONFIG: st_next.cfg = reg_wdata_i;
                ADDR_THS_MSB: st_next.dbnc_mode = reg_wdata_i[THS_DBNC_MODE];
                ADDR_THS_LSB: st_next.ths[7:0] = reg_wdata_i;
                ADDR_DBNC_CNT: st_next.dbnc_cnt = reg_wdata_i;
                ADDR_INITX_MSB: st_next.init_x[15:8] = reg_wdata_i;
                ADDR_INITX_LSB: st_next.init_x[7:0] = reg_wdata_i;
                ADDR_INITY_MSB: st_next.init_y[15:8] = reg_wdata_i;
                ADDR_INITY_LSB: st_next.init_y[7:0] = reg_wdata_i;
                ADDR_INITZ_MSB: st_next.init_z[15:8] = reg_wdata_i;
                ADDR_INITZ_LSB: st_next.init_z[7:0] = reg_wdata_i;
                default: st_next.cfg = st_reg.cfg;
            endcase
            if (reg_addr_i == ADDR_THS_MSB) begin
                st_next.ths[14:8] = reg_wdata_i[6:0];
            end
        end
        // Debounce evaluation while enabled.
        if (!st_reg.cfg[CFG_ENABLE]) begin
            st_next.dcnt = 8'h00;
        end else if (tick) begin
            if (evt) begin
                st_next.dcnt = 8'h00;
                if (!st_reg.cfg[CFG_REF_HOLD]) begin
                    st_next.ref_x = mag_x_i;
                    st_next.ref_y = mag_y_i;
                    st_next.ref_z = mag_z_i;
                end
            end else if (above) begin
                st_next.dcnt = st_reg.dcnt + 8'h01;
            end else if (st_reg.dbnc_mode) begin
                st_next.dcnt = 8'h00;
            end else if (st_reg.dcnt != 8'h00) begin
                st_next.dcnt = st_reg.dcnt - 8'h01;
            end
        end
        // Turning the function on reloads the references from the chosen source.
        if (en_rise) begin
            st_next.dcnt = 8'h00;
            if (reg_wdata_i[CFG_INIT_SEL]) begin
                st_next.ref_x = st_reg.init_x;
                st_next.ref_y = st_reg.init_y;
                st_next.ref_z = st_reg.init_z;
            end else begin
                st_next.ref_x = mag_x_i;
                st_next.ref_y = mag_y_i;
                st_next.ref_z = mag_z_i;
            end
        end
        // Manual mode mirrors preset writes into the references.
        if (manual && !en_rise) begin
            st_next.ref_x = st_next.init_x;
            st_next.ref_y = st_next.init_y;
            st_next.ref_z = st_next.init_z;
        end
        // Flag: latched holds until a source read, set beating clear.
        if (st_reg.cfg[CFG_LATCH]) begin
            if (evt) begin
                st_next.flag = 1'b1;
            end else if (src_rd) begin
                st_next.flag = 1'b0;
            end
        end else if (!st_reg.cfg[CFG_ENABLE]) begin
            st_next.flag = 1'b0;
        end else if (tick) begin
            st_next.flag = evt;
        end
        // Read data is captured on the read strobe.
        if (reg_rd_i) begin
            st_next.rdata = read_mux(st_reg, reg_addr_i);
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_reg <= '0;
            st_reg.cfg <= REG_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs. The pins follow the flag, gated and routed by the configuration.
    assign reg_rdata_o = st_reg.rdata;
    assign vecm_flag_o = st_reg.flag;
    assign wake_activity_o = st_reg.cfg[CFG_WAKE] && st_reg.flag;
    assign irq_line_a_o = st_reg.cfg[CFG_IRQ_EN] && st_reg.cfg[CFG_ROUTE] && st_reg.flag;
    assign irq_line_b_o = st_reg.cfg[CFG_IRQ_EN] && !st_reg.cfg[CFG_ROUTE] && st_reg.flag;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // Steps of an enable write with each initialisation source.
    sequence s_en_from_sample;
        en_rise && !reg_wdata_i[CFG_INIT_SEL];
    endsequence
    sequence s_en_from_preset;
        en_rise && reg_wdata_i[CFG_INIT_SEL];
    endsequence

    a_latch_hold: assert property (st_reg.cfg[CFG_LATCH] && st_reg.flag && !src_rd && !reg_wr_i |=> st_reg.flag)
        else $error("latched flag dropped without a source read");
    a_unlatched_follow: assert property (!st_reg.cfg[CFG_LATCH] && tick && st_reg.cfg[CFG_ENABLE] && !reg_wr_i
        |=> st_reg.flag == $past(evt))
        else $error("unlatched flag did not follow the evaluation");
    a_init_sample: assert property (s_en_from_sample |=> st_reg.ref_x == $past(mag_x_i))
        else $error("reference not loaded from the sample on enable");
    a_init_preset: assert property (s_en_from_preset |=> st_reg.ref_z == $past(st_reg.init_z))
        else $error("reference not loaded from the preset on enable");
    a_ref_update: assert property (evt && !st_reg.cfg[CFG_REF_HOLD] && !reg_wr_i |=> st_reg.ref_y == $past(mag_y_i))
        else $error("event did not refresh the reference");
    a_ref_hold: assert property (evt && st_reg.cfg[CFG_REF_HOLD] && !manual && !reg_wr_i |=> $stable(st_reg.ref_x))
        else $error("held reference changed on event");
    a_manual_ref: assert property (manual && reg_wr_i && reg_addr_i == ADDR_INITX_LSB && !en_rise
        |=> st_reg.ref_x[7:0] == $past(reg_wdata_i))
        else $error("preset write not applied to the reference");
    a_disabled_idle: assert property (!st_reg.cfg[CFG_ENABLE] && !en_rise |=> st_reg.dcnt == 8'h00 && !evt)
        else $error("disabled function still counting");
    a_dbnc_clear: assert property (st_reg.cfg[CFG_ENABLE] && tick && !above && st_reg.dbnc_mode && !reg_wr_i
        |=> st_reg.dcnt == 8'h00)
        else $error("debounce counter not cleared below threshold");
    a_irq_route: assert property (st_reg.flag && st_reg.cfg[CFG_IRQ_EN]
        |-> (irq_line_a_o ^ irq_line_b_o) && irq_line_a_o == st_reg.cfg[CFG_ROUTE])
        else $error("interrupt not on the selected line");
endmodule
`default_nettype wire

// ===== vecm_host_model.sv
// Host-side model that drives register accesses and magnetic samples and notes expected results.
`timescale 1ns/1ps
`default_nettype none
module vecm_host_model
    import vecm_pkg::*;
(
    // Clock.
    input wire logic mclk_i,
    // Register access drive.
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    // Sample drive.
    output logic sample_valid_o,
    output logic hybrid_o,
    output logic signed [MAG_W-1:0] mag_x_o,
    output logic signed [MAG_W-1:0] mag_y_o,
    output logic signed [MAG_W-1:0] mag_z_o
);
    // Expected read data and expected {flag, wake, line a, line b}, oldest first.
    logic [7:0] rq[$];
    logic [3:0] pq[$];

    // Quiet levels at time zero.
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        sample_valid_o = 1'b0;
        hybrid_o = 1'b0;
        put(16'sh0000, 16'sh0000, 16'sh0000);
    end

    // Places a sample on the data lines without a tick.
    task automatic put(input logic signed [15:0] x, input logic signed [15:0] y, input logic signed [15:0] z);
        mag_x_o = x;
        mag_y_o = y;
        mag_z_o = z;
    endtask

    // One register cycle; for a read the data argument is the expected value.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        reg_wr_o = w;
        reg_rd_o = !w;
        reg_addr_o = a;
        reg_wdata_o = d;
        if (!w) begin
            rq.push_back(d);
        end
        @(posedge mclk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        // Released lines show the inverse so stale data cannot pass as valid.
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask

    // One sample tick; ticks stand in for an output rate the detector supports.
    task automatic smp(input logic signed [15:0] x, input logic signed [15:0] y, input logic [3:0] e);
        @(posedge mclk_i);
        #1;
        put(x, y, 16'sh0000);
        sample_valid_o = 1'b1;
        pq.push_back(e);
        @(posedge mclk_i);
        #1;
        sample_valid_o = 1'b0;
        put(~x, ~y, 16'shffff);
    endtask
endmodule
`default_nettype wire

// ===== mag_vector_change_detect_tb_top.sv
// Self-checking testbench for the vector-change detector.
`timescale 1ns/1ps
`default_nettype none
module mag_vector_change_detect_tb_top
    import vecm_pkg::*;
;
    logic mclk, srst, reg_wr, reg_rd, smp_v, hyb, flag, wake, irq_a, irq_b, rd_q, sv_q;
    logic [7:0] reg_addr, reg_wdata, rdata;
    logic signed [MAG_W-1:0] mx, my, mz;
    integer miscompares = 0;
    integer n_compared = 0;
    integer seed = 30;

    // Host model and design.
    vecm_host_model h_u (.mclk_i(mclk), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .sample_valid_o(smp_v), .hybrid_o(hyb), .mag_x_o(mx), .mag_y_o(my), .mag_z_o(mz));
    vecm_detect dut_u (.mclk_i(mclk), .srst_i(srst), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata), .sample_valid_i(smp_v), .hybrid_i(hyb), .mag_x_i(mx),
        .mag_y_i(my), .mag_z_i(mz), .vecm_flag_o(flag), .wake_activity_o(wake), .irq_line_a_o(irq_a),
        .irq_line_b_o(irq_b));

    // Free-running clock at 5 ns.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Compares one value and reports a difference.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Below-threshold offset on the y axis, kept within seven counts.
    function automatic logic signed [15:0] rnd();
        return 16'($signed($random(seed) % 8));
    endfunction

    // Remembers which edges carried a read or a sample.
    always @(posedge mclk) begin
        rd_q <= reg_rd;
        sv_q <= smp_v;
    end

    // Results are settled by the falling edge after the taking edge.
    always @(negedge mclk) begin
        if (rd_q) begin
            check(rdata, h_u.rq.pop_front());
        end
        if (sv_q) begin
            check({4'h0, flag, wake, irq_a, irq_b}, {4'h0, h_u.pq.pop_front()});
        end
    end

    // Cuts a hang short.
    initial begin
        #50000;
        miscompares++;
        test_done();
    end

    // Main sequence.
    initial begin
        srst = 1'b1;
        rd_q = 1'b0;
        sv_q = 1'b0;
        repeat (16) @(posedge mclk);
        #1;
        srst = 1'b0;
        // Reset values, unmapped and read-only places.
        h_u.acc(1'b0, ADDR_CONFIG, REG_RESET);
        h_u.acc(1'b0, 8'h50, 8'h00);
        h_u.acc(1'b1, ADDR_EVENT_SRC, 8'hff);
        h_u.acc(1'b0, ADDR_EVENT_SRC, 8'h00);
        h_u.acc(1'b1, ADDR_THS_LSB, 8'h0a);
        h_u.acc(1'b0, ADDR_THS_LSB, 8'h0a);
        $display("test registers done");
        // Latched, refs from current sample, refs follow events, line a.
        h_u.put(16'sd100, 16'sd0, 16'sd0);
        h_u.acc(1'b1, ADDR_CONFIG, 8'h4f);
        h_u.smp(16'sd100, rnd(), 4'h0);
        h_u.smp(16'sd120, 16'sd0, 4'he);
        h_u.smp(16'sd120, rnd(), 4'he);
        h_u.acc(1'b0, ADDR_EVENT_SRC, 8'h02);
        h_u.acc(1'b0, ADDR_EVENT_SRC, 8'h00);
        h_u.smp(16'sd120, rnd(), 4'h0);
        $display("test latched done");
        // Unlatched, refs held, line b, then disabled.
        h_u.acc(1'b1, ADDR_CONFIG, 8'h00);
        h_u.put(16'sd0, 16'sd0, 16'sd0);
        h_u.acc(1'b1, ADDR_CONFIG, 8'h1a);
        h_u.smp(16'sd50, 16'sd0, 4'h9);
        h_u.smp(16'sd0, rnd(), 4'h0);
        h_u.smp(16'sd50, 16'sd0, 4'h9);
        h_u.acc(1'b1, ADDR_CONFIG, 8'h00);
        h_u.smp(16'sd50, 16'sd0, 4'h0);
        $display("test unlatched done");
        // Preset refs, then live preset updates.
        h_u.acc(1'b1, ADDR_INITX_MSB, 8'h01);
        h_u.put(16'sd0, 16'sd0, 16'sd0);
        h_u.acc(1'b1, ADDR_CONFIG, 8'h3b);
        h_u.smp(16'sd256, rnd(), 4'h0);
        h_u.smp(16'sd0, 16'sd0, 4'ha);
        h_u.acc(1'b1, ADDR_INITX_MSB, 8'h00);
        h_u.smp(16'sd0, rnd(), 4'h0);
        $display("test preset done");
        // Debounce of two in clearing mode, interrupt disabled.
        h_u.acc(1'b1, ADDR_CONFIG, 8'h00);
        h_u.acc(1'b1, ADDR_DBNC_CNT, 8'h02);
        h_u.acc(1'b1, ADDR_THS_MSB, 8'h80);
        h_u.put(16'sd0, 16'sd0, 16'sd0);
        h_u.acc(1'b1, ADDR_CONFIG, 8'h18);
        h_u.smp(16'sd50, 16'sd0, 4'h0);
        h_u.smp(16'sd50, 16'sd0, 4'h0);
        h_u.smp(16'sd0, rnd(), 4'h0);
        h_u.smp(16'sd50, 16'sd0, 4'h0);
        h_u.smp(16'sd50, 16'sd0, 4'h0);
        h_u.smp(16'sd50, 16'sd0, 4'h8);
        $display("test debounce done");
        // Second reset in mid-run; it also puts the hybrid divider in a known phase.
        @(posedge mclk);
        #1;
        srst = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        srst = 1'b0;
        h_u.acc(1'b0, ADDR_EVENT_SRC, 8'h00);
        h_u.acc(1'b0, ADDR_CONFIG, REG_RESET);
        h_u.acc(1'b1, ADDR_THS_LSB, 8'h0a);
        h_u.put(16'sd0, 16'sd0, 16'sd0);
        h_u.acc(1'b1, ADDR_CONFIG, 8'h1a);
        // Hybrid mode: only every second sample is evaluated, the first one after reset is skipped.
        h_u.hybrid_o = 1'b1;
        h_u.smp(16'sd50, 16'sd0, 4'h0);
        h_u.smp(16'sd50, 16'sd0, 4'h9);
        h_u.smp(16'sd0, rnd(), 4'h9);
        h_u.smp(16'sd0, rnd(), 4'h0);
        h_u.hybrid_o = 1'b0;
        $display("test hybrid done");
        repeat (4) @(posedge mclk);
        test_done();
    end
endmodule
`default_nettype wire
